// ==== design/tth_defs.vh ====
// Offsets, field positions, reset values and timing counts of the trigger
`ifndef TTH_DEFS_VH
`define TTH_DEFS_VH
`define TTH_CLK_HZ 20000000
`define TTH_HUNDREDTH_NS 10000000
`define TTH_CLK_PERIOD_NS 50
`define TTH_TICK_CYCLES (`TTH_HUNDREDTH_NS / `TTH_CLK_PERIOD_NS)
`define TTH_GATE_MAX 16'h270f
`define TTH_FREQ_THR_MAX 16'h270f
`define TTH_GAIN_MAX 32'sd1000
`define TTH_GAIN_MIN (-32'sd1000)
`define TTH_OFFS_MAX 32'sd10000
`define TTH_OFFS_MIN (-32'sd10000)
`define TTH_THR_MAX 32'sd20000
`define TTH_THR_MIN (-32'sd20000)
`define TTH_GAIN_SCALE 32'sd100
`define TTH_REG_CTRL 8'h00
`define TTH_REG_GATE 8'h04
`define TTH_REG_ON 8'h08
`define TTH_REG_OFF 8'h0c
`define TTH_REG_GAIN 8'h10
`define TTH_REG_OFFS 8'h14
`define TTH_REG_DEC 8'h18
`define TTH_REG_STAT 8'h1c
`define TTH_REG_COUNT 8'h20
`define TTH_REG_VALUE 8'h24
`define TTH_CTRL_MODE 0
`define TTH_CTRL_GATE_SEL 1
`define TTH_CTRL_ON_SEL 2
`define TTH_CTRL_OFF_SEL 3
`define TTH_GATE_RST 16'h0064
`define TTH_GAIN_RST 16'h0064
`define TTH_RESP_OKAY 2'b00
`define TTH_RESP_SLVERR 2'b10
`endif

// ==== design/tth_edge_counter.v ====
// Synchronised rising-edge pulse counter for the frequency front end
`timescale 1ns/1ps
module tth_edge_counter
(
  // Clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // Pulse pin and control
  input wire pulse_in,
  input wire clear_in,
  // Result
  output reg [15:0] count_out
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  wire rise;

  // 20 MHz sampling keeps 5 kHz pulses far below Nyquist
  assign rise = sync2_q & ~prev_q;

  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      count_out <= 16'h0000;
    end
    else
    begin
      sync1_q <= pulse_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      // Edge in clear cycle starts the new interval
      if (clear_in)
        count_out <= {15'h0000, rise};
      else if (rise && count_out != 16'hffff)
        count_out <= count_out + 16'h0001;
    end
  end
endmodule // tth_edge_counter

// ==== design/tth_trigger.v ====
// Threshold trigger with hysteresis, frequency and analog front ends
`timescale 1ns/1ps
`include "tth_defs.vh"
module tth_trigger
(
  // Clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Front end inputs
  input wire pulse_in,
  input wire signed [15:0] analog_value_in,
  // Live values of neighbouring blocks
  input wire [15:0] ext_gate_in,
  input wire signed [15:0] ext_on_in,
  input wire signed [15:0] ext_off_in,
  // Result
  output reg trig_out,
  output reg [15:0] measured_count_out
);
  reg mode_q;
  reg gate_sel_q;
  reg on_sel_q;
  reg off_sel_q;
  reg [15:0] gate_q;
  reg signed [15:0] on_q;
  reg signed [15:0] off_q;
  reg signed [15:0] gain_q;
  reg signed [15:0] offs_q;
  reg [1:0] dec_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_have_q;
  reg w_have_q;
  reg [18:0] tick_cnt_q;
  reg [15:0] gate_cnt_q;
  reg signed [31:0] analog_value_q;
  reg gate_end_q;
  wire [15:0] count_raw;
  wire tick;
  wire [15:0] gate_cur;
  wire signed [31:0] on_cur;
  wire signed [31:0] off_cur;
  wire signed [31:0] cmp_val;
  wire signed [31:0] an_calc;
  wire q_next;
  wire gate_done;
  wire wr_fire;
  wire [31:0] wr_val;
  wire signed [31:0] gain_lim;
  wire signed [31:0] offs_lim;

  // Clamp a signed value into a range
  function signed [31:0] clamp;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (v < lo)
        clamp = lo;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v;
    end
  endfunction

  // Hysteresis or window decision
  function decide;
    input signed [31:0] v;
    input signed [31:0] on_t;
    input signed [31:0] off_t;
    input prev;
    begin
      if (on_t >= off_t)
      begin
        if (v > on_t)
          decide = 1'b1;
        else if (v <= off_t)
          decide = 1'b0;
        else
          decide = prev;
      end
      else
        decide = (v >= on_t) && (v < off_t);
    end
  endfunction

  // Merge byte lanes into a register value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  tth_edge_counter u_cnt
  (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pulse_in(pulse_in),
    .clear_in(gate_done),
    .count_out(count_raw)
  );

  // Live gate value clamped to 99.99 s
  assign gate_cur = gate_sel_q ?
    ((ext_gate_in > `TTH_GATE_MAX) ? `TTH_GATE_MAX : ext_gate_in) : gate_q;
  // Frequency mode thresholds are unsigned 0..9999
  assign on_cur = mode_q ? clamp({{16{1'b0}}, on_q}, 32'sd0, {16'h0000, `TTH_FREQ_THR_MAX})
    : clamp(on_sel_q ? {{16{ext_on_in[15]}}, ext_on_in} : {{16{on_q[15]}}, on_q},
            `TTH_THR_MIN, `TTH_THR_MAX);
  assign off_cur = mode_q ? clamp({{16{1'b0}}, off_q}, 32'sd0, {16'h0000, `TTH_FREQ_THR_MAX})
    : clamp(off_sel_q ? {{16{ext_off_in[15]}}, ext_off_in} : {{16{off_q[15]}}, off_q},
            `TTH_THR_MIN, `TTH_THR_MAX);
  // Gain in hundredths; signed casts keep negative products truncating toward zero
  assign an_calc = $signed({{16{analog_value_in[15]}}, analog_value_in})
    * $signed({{16{gain_q[15]}}, gain_q}) / `TTH_GAIN_SCALE
    + $signed({{16{offs_q[15]}}, offs_q});
  // Timebase runs from reset whatever the mode
  assign tick = ({13'h0000, tick_cnt_q} == (`TTH_TICK_CYCLES - 1));
  // Zero gate never closes, the count keeps running
  assign gate_done = tick && (gate_cur != 16'h0000) && (gate_cnt_q + 16'h0001 >= gate_cur);
  assign cmp_val = mode_q ? {16'h0000, measured_count_out} : analog_value_q;
  assign q_next = decide(cmp_val, on_cur, off_cur, trig_out);
  // A pending response holds off the next register update
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // One hundredth-second timebase and gate interval
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tick_cnt_q <= 19'h0_0000;
      gate_cnt_q <= 16'h0000;
      measured_count_out <= 16'h0000;
      gate_end_q <= 1'b0;
      analog_value_q <= 32'h0000_0000;
      trig_out <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick ? 19'h0_0000 : tick_cnt_q + 19'h0_0001;
      gate_end_q <= gate_done;
      if (gate_done)
      begin
        gate_cnt_q <= 16'h0000;
        measured_count_out <= count_raw;
      end
      else if (tick)
        gate_cnt_q <= gate_cnt_q + 16'h0001;
      analog_value_q <= an_calc;
      // Frequency result judged one cycle after capture
      if (!mode_q || gate_end_q)
        trig_out <= q_next;
    end
  end

  assign wr_val = merge(32'h0000_0000, w_data_q, w_strb_q);
  // Clamp the sign-extended low 16 bits, then cut to the 16-bit field
  assign gain_lim = clamp({{16{wr_val[15]}}, wr_val[15:0]},
                          `TTH_GAIN_MIN, `TTH_GAIN_MAX);
  assign offs_lim = clamp({{16{wr_val[15]}}, wr_val[15:0]},
                          `TTH_OFFS_MIN, `TTH_OFFS_MAX);

  // Register write path
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TTH_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      mode_q <= 1'b0;
      gate_sel_q <= 1'b0;
      on_sel_q <= 1'b0;
      off_sel_q <= 1'b0;
      gate_q <= `TTH_GATE_RST;
      on_q <= 16'h0000;
      off_q <= 16'h0000;
      gain_q <= `TTH_GAIN_RST;
      offs_q <= 16'h0000;
      dec_q <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TTH_RESP_OKAY;
        case (aw_addr_q)
          `TTH_REG_CTRL:
          begin
            if (w_strb_q[0])
            begin
              mode_q <= w_data_q[`TTH_CTRL_MODE];
              gate_sel_q <= w_data_q[`TTH_CTRL_GATE_SEL];
              on_sel_q <= w_data_q[`TTH_CTRL_ON_SEL];
              off_sel_q <= w_data_q[`TTH_CTRL_OFF_SEL];
            end
          end
          `TTH_REG_GATE:
            gate_q <= (wr_val[15:0] > `TTH_GATE_MAX) ? `TTH_GATE_MAX : wr_val[15:0];
          `TTH_REG_ON:
            on_q <= wr_val[15:0];
          `TTH_REG_OFF:
            off_q <= wr_val[15:0];
          `TTH_REG_GAIN:
            gain_q <= gain_lim[15:0];
          `TTH_REG_OFFS:
            offs_q <= offs_lim[15:0];
          `TTH_REG_DEC:
            dec_q <= wr_val[1:0];
          `TTH_REG_STAT, `TTH_REG_COUNT, `TTH_REG_VALUE:
            s_axi_bresp <= `TTH_RESP_OKAY;
          default:
            s_axi_bresp <= `TTH_RESP_SLVERR;
        endcase
      end
    end
  end

  // Register read path
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TTH_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TTH_RESP_OKAY;
        case (s_axi_araddr)
          `TTH_REG_CTRL:
            s_axi_rdata <= {28'h000_0000, off_sel_q, on_sel_q, gate_sel_q, mode_q};
          `TTH_REG_GATE:
            s_axi_rdata <= {16'h0000, gate_q};
          `TTH_REG_ON:
            s_axi_rdata <= {{16{on_q[15]}}, on_q};
          `TTH_REG_OFF:
            s_axi_rdata <= {{16{off_q[15]}}, off_q};
          `TTH_REG_GAIN:
            s_axi_rdata <= {{16{gain_q[15]}}, gain_q};
          `TTH_REG_OFFS:
            s_axi_rdata <= {{16{offs_q[15]}}, offs_q};
          `TTH_REG_DEC:
            s_axi_rdata <= {30'h0000_0000, dec_q};
          `TTH_REG_STAT:
            s_axi_rdata <= {31'h0000_0000, trig_out};
          `TTH_REG_COUNT:
            s_axi_rdata <= {16'h0000, measured_count_out};
          `TTH_REG_VALUE:
            s_axi_rdata <= analog_value_q;
          // Unmapped reads return zero with an error
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TTH_RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule // tth_trigger

// ==== testbench/tb_top.sv ====
// Self-checking bench for the threshold trigger
`timescale 1ns/1ps
`include "tth_defs.vh"
module tb_top;
  reg ref_clk_in, resetn_in, run;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg signed [15:0] analog_value_in;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire pulse_in, trig_out;
  wire [15:0] ext_gate_in, measured_count_out;
  wire signed [15:0] ext_on_in, ext_off_in;
  integer num_errors, n_tests, cyc, i;
  tth_trigger u_tth_trigger (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pulse_in(pulse_in),
    .analog_value_in(analog_value_in), .ext_gate_in(ext_gate_in), .ext_on_in(ext_on_in),
    .ext_off_in(ext_off_in), .trig_out(trig_out), .measured_count_out(measured_count_out));
  tth_far_model u_tth_far_model (.ref_clk_in(ref_clk_in), .run_in(run),
    .pulse_out(pulse_in), .ext_gate_out(ext_gate_in), .ext_on_out(ext_on_in),
    .ext_off_out(ext_off_in));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    begin
      @(posedge ref_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge ref_clk_in);
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
    end
  endtask
  // Error replies carry no data worth comparing
  task rc(input [7:0] a, input [1:0] er, input [15:0] e);
    begin
      @(posedge ref_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge ref_clk_in);
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, (er == 2'h0) ? s_axi_rdata[15:0] : e}, {er, e});
    end
  endtask
  task an(input [15:0] v, input e);
    begin
      @(posedge ref_clk_in);
      analog_value_in <= v;
      repeat (3) @(posedge ref_clk_in);
      chk(trig_out, e);
    end
  endtask
  // Gate ends are 200000 cycles apart
  task waitq(input e);
    begin
      i = 0;
      while (trig_out !== e && i < 250000)
      begin
        @(posedge ref_clk_in);
        i = i + 1;
      end
      chk(trig_out, e);
      chk(measured_count_out, 16'h0032);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    cyc = 0;
    while (cyc < 450000)
    begin
      @(posedge ref_clk_in);
      cyc = cyc + 1;
    end
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    resetn_in = 1'b0;
    run = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    analog_value_in = 16'h0000;
    repeat (12) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    // Pulses run from release so the first gate end already holds a full count
    run <= 1'b1;
    rc(`TTH_REG_CTRL, 2'h0, 16'h0000);
    rc(`TTH_REG_GATE, 2'h0, 16'h0064);
    rc(`TTH_REG_GAIN, 2'h0, 16'h0064);
    rc(8'h40, `TTH_RESP_SLVERR, 16'h0000);
    wr(8'h40, 32'h0000_0001, `TTH_RESP_SLVERR);
    wr(`TTH_REG_STAT, 32'h0000_0001, 2'h0);
    rc(`TTH_REG_STAT, 2'h0, 16'h0000);
    wr(`TTH_REG_GAIN, 32'h0000_07d0, 2'h0);
    rc(`TTH_REG_GAIN, 2'h0, 16'h03e8);
    wr(`TTH_REG_GAIN, 32'h0000_f830, 2'h0);
    rc(`TTH_REG_GAIN, 2'h0, 16'hfc18);
    wr(`TTH_REG_OFFS, 32'h0000_4e20, 2'h0);
    rc(`TTH_REG_OFFS, 2'h0, 16'h2710);
    wr(`TTH_REG_GATE, 32'h0000_2710, 2'h0);
    rc(`TTH_REG_GATE, 2'h0, 16'h270f);
    wr(`TTH_REG_ON, 32'h0000_b1e0, 2'h0);
    rc(`TTH_REG_ON, 2'h0, 16'hb1e0);
    $display("test registers done");
    wr(`TTH_REG_GAIN, 32'h0000_00c8, 2'h0);
    wr(`TTH_REG_OFFS, 32'h0000_0064, 2'h0);
    wr(`TTH_REG_ON, 32'h0000_012c, 2'h0);
    wr(`TTH_REG_OFF, 32'h0000_0064, 2'h0);
    an(16'h0032, 1'b0);
    rc(`TTH_REG_VALUE, 2'h0, 16'h00c8);
    an(16'h0096, 1'b1);
    an(16'h0064, 1'b1);
    an(16'h0000, 1'b0);
    an(16'h004b, 1'b0);
    wr(`TTH_REG_DEC, 32'h0000_0003, 2'h0);
    an(16'h0096, 1'b1);
    wr(`TTH_REG_ON, 32'h0000_0064, 2'h0);
    wr(`TTH_REG_OFF, 32'h0000_012c, 2'h0);
    an(16'h0000, 1'b1);
    an(16'h0064, 1'b0);
    an(16'hffff, 1'b0);
    rc(`TTH_REG_VALUE, 2'h0, 16'h0062);
    wr(`TTH_REG_CTRL, 32'h0000_000c, 2'h0);
    an(16'h004b, 1'b0);
    an(16'h0096, 1'b1);
    an(16'h0000, 1'b0);
    $display("test analog done");
    wr(`TTH_REG_ON, 32'h0000_0031, 2'h0);
    wr(`TTH_REG_OFF, 32'h0000_000a, 2'h0);
    wr(`TTH_REG_CTRL, 32'h0000_0003, 2'h0);
    waitq(1'b1);
    wr(`TTH_REG_ON, 32'h0000_003c, 2'h0);
    wr(`TTH_REG_OFF, 32'h0000_0032, 2'h0);
    // Give the new thresholds time to show before looking; the result must hold until the next gate end
    repeat (4) @(posedge ref_clk_in);
    chk(trig_out, 1'b1);
    waitq(1'b0);
    $display("test frequency done");
    report_and_stop;
  end
endmodule // tb_top

// ==== testbench/tth_far_model.sv ====
// Far side: fast pulse source and neighbour block values
`timescale 1ns/1ps
module tth_far_model
(
  // Clock and enable
  input wire ref_clk_in,
  input wire run_in,
  // To the trigger
  output reg pulse_out = 1'b0,
  output wire [15:0] ext_gate_out,
  output wire [15:0] ext_on_out,
  output wire [15:0] ext_off_out
);
  reg [11:0] half_q = 12'h000;
  // One hundredth gate, hysteresis pair 300 over 100
  assign ext_gate_out = 16'h0001;
  assign ext_on_out = 16'h012c;
  assign ext_off_out = 16'h0064;
  // Direct fast input at its ceiling, so 50 edges per gate
  always @(posedge ref_clk_in)
  begin
    half_q <= (half_q == 12'h7cf || !run_in) ? 12'h000 : half_q + 12'h001;
    if (run_in && half_q == 12'h7cf)
      pulse_out <= ~pulse_out;
  end
endmodule // tth_far_model

// ==== testbench/tth_trigger_sva.sv ====
// Bus handshake and measured count checks on the trigger ports
`timescale 1ns/1ps
module tth_trigger_sva
(
  // Clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // Bus channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Result
  input wire [15:0] measured_count_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  aw_cause_a: assert property (s_axi_awready |-> $past(s_axi_awvalid))
    else $error("awready without awvalid");
  ar_cause_a: assert property (s_axi_arready |-> $past(s_axi_arvalid))
    else $error("arready without arvalid");
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid not cleared");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  count_steady_a: assert property (
    $changed(measured_count_out) |=> $stable(measured_count_out)[*8])
    else $error("count changed twice in a gate");
endmodule // tth_trigger_sva

bind tth_trigger tth_trigger_sva u_tth_trigger_sva
(
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .measured_count_out(measured_count_out)
);
